// *** hdl/mono_mix_pkg.sv ***
/*
 Register map, field positions and reset values of the mono mixing and
 mono output control registers.
 Assumes an 8-bit register port with byte addresses as printed.
*/
package mono_mix_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [7:0] MONO_MIX_SELECT_ADDR = 8'h10;
    localparam logic [7:0] DIFFERENTIAL_INPUT_SELECT_ADDR = 8'h11;
    localparam logic [7:0] MONO_OUTPUT_SOURCE_SELECT_ADDR = 8'h12;
    localparam logic [7:0] MONO_OUTPUT_LEVEL_ADDR = 8'h13;
    // Reset values
    localparam logic [7:0] MONO_MIX_SELECT_RST = 8'h00;
    localparam logic [7:0] DIFFERENTIAL_INPUT_SELECT_RST = 8'h00;
    localparam logic [7:0] MONO_OUTPUT_SOURCE_SELECT_RST = 8'h00;
    localparam logic [7:0] MONO_OUTPUT_LEVEL_RST = 8'h10;
    // Writable bit masks; other bits read zero
    localparam logic [7:0] MONO_MIX_SELECT_MASK = 8'h3F;
    localparam logic [7:0] DIFFERENTIAL_INPUT_SELECT_MASK = 8'h07;
    localparam logic [7:0] MONO_OUTPUT_SOURCE_SELECT_MASK = 8'hFF;
    localparam logic [7:0] MONO_OUTPUT_LEVEL_MASK = 8'h7F;
    // Field positions, mono_mix_select
    localparam int PAIR_ONE_HP_BIT = 0;
    localparam int PAIR_ONE_LO_BIT = 1;
    localparam int PAIR_TWO_HP_BIT = 2;
    localparam int PAIR_TWO_LO_BIT = 3;
    localparam int PAIR_THREE_HP_BIT = 4;
    localparam int PAIR_THREE_LO_BIT = 5;
    // Field positions, differential_input_select
    localparam int DIFF_ENABLE_BIT = 0;
    localparam int DIFF_TO_HP_BIT = 1;
    localparam int DIFF_TO_MONO_BIT = 2;
    // Field positions, mono_output_source_select
    localparam int DAC_LEFT_MONO_BIT = 0;
    localparam int DAC_RIGHT_MONO_BIT = 1;
    localparam int LEFT_ONE_MONO_BIT = 2;
    localparam int RIGHT_ONE_MONO_BIT = 3;
    localparam int LEFT_TWO_MONO_BIT = 4;
    localparam int RIGHT_TWO_MONO_BIT = 5;
    localparam int LEFT_THREE_MONO_BIT = 6;
    localparam int RIGHT_THREE_MONO_BIT = 7;
    // Field positions, mono_output_level
    localparam int ATTEN_LSB = 0;
    localparam int ATTEN_W = 4;
    localparam int MUTE_BIT = 4;
    localparam int GAIN_BIT = 5;
    localparam int POWER_BIT = 6;
    localparam logic [3:0] ATTEN_MUTED = 4'h0;
endpackage

// *** hdl/mono_mix_route_control.sv ***
/*
 Mono mixing and mono output control registers of an audio codec, with
 the switch controls they derive.
 Assumes a same-clock register port master and an asynchronous,
 active-low power-down pin that is synchronised here.
*/
// Function
// - Per pair, a bit adds the (L+R)/2 average into the headphone amp.
// - Per pair, a bit adds the (L+R)/2 average into both line outputs.
// - Differential enable turns pair one into one source to lineout.
// - Differential-to-headphone bit acts only while differential enabled.
// - Differential-to-mono bit acts only while differential enabled.
// - Two bits add DAC left and right into the mono sum.
// - Six bits add each single-ended line input into the mono sum.
// - Four-bit mono attenuation, reset zero, used only when unmuted.
// - Mono mute resets set; it forces mute and ignores attenuation.
// - Mono power resets off; while off the mono pin is high impedance.
// - Power-down pin low resets every register to its default.
module mono_mix_route_control
    import mono_mix_pkg::*;
(
    input wire logic ref_clk, // 200 MHz clock
    input wire logic rst, // Async reset, active high
    input wire logic powerDownPinN, // Power-down pin, low = down
    input wire logic [ADDR_W-1:0] regAddr, // Register address
    input wire logic [DATA_W-1:0] regWrData, // Write data
    input wire logic regWrStb, // Write strobe
    input wire logic regRdStb, // Read strobe
    output logic [DATA_W-1:0] regRdData, // Read data, next cycle
    output logic [2:0] pairAvgToHeadphone, // Pair 3..1 average to HP
    output logic [2:0] pairAvgToLineout, // Pair 3..1 average to lineout
    output logic differentialMode, // Pair one used as IN+/IN-
    output logic differentialToLineout, // Diff source to lineout
    output logic differentialToHeadphone, // Diff source to HP
    output logic differentialToMonoOutput, // Diff source to mono out
    output logic dacLeftToMono, // DAC left into mono sum
    output logic dacRightToMono, // DAC right into mono sum
    output logic [5:0] lineInToMono, // R3 L3 R2 L2 R1 L1 to mono
    output logic [3:0] monoAttenuation, // Effective attenuation code
    output logic monoMuted, // Mono output muted
    output logic monoDacGain, // 1 = +6 dB DAC gain
    output logic monoPower, // Mono stage powered
    output logic monoPinOe // Mono pin driven, low = hi-Z
);
    logic pdnMeta_q;
    logic pdnSync_q;
    logic [7:0] mixSel_q;
    logic [7:0] diffSel_q;
    logic [7:0] srcSel_q;
    logic [7:0] level_q;
    logic [7:0] rdData_d;
    logic [7:0] rdData_q;
    logic regClear;

    // Power-down pin synchroniser
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pdnMeta_q <= 1'b0;
            pdnSync_q <= 1'b0;
        end else begin
            pdnMeta_q <= powerDownPinN;
            pdnSync_q <= pdnMeta_q;
        end
    end

    // Pin low holds registers at default
    assign regClear = ~pdnSync_q;

    // Mono mixing register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mixSel_q <= MONO_MIX_SELECT_RST;
        end else if (regClear) begin
            mixSel_q <= MONO_MIX_SELECT_RST;
        end else if (regWrStb && regAddr == MONO_MIX_SELECT_ADDR) begin
            mixSel_q <= regWrData & MONO_MIX_SELECT_MASK;
        end
    end

    // Differential select register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            diffSel_q <= DIFFERENTIAL_INPUT_SELECT_RST;
        end else if (regClear) begin
            diffSel_q <= DIFFERENTIAL_INPUT_SELECT_RST;
        end else if (regWrStb &&
                     regAddr == DIFFERENTIAL_INPUT_SELECT_ADDR) begin
            diffSel_q <= regWrData & DIFFERENTIAL_INPUT_SELECT_MASK;
        end
    end

    // Mono source select register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            srcSel_q <= MONO_OUTPUT_SOURCE_SELECT_RST;
        end else if (regClear) begin
            srcSel_q <= MONO_OUTPUT_SOURCE_SELECT_RST;
        end else if (regWrStb &&
                     regAddr == MONO_OUTPUT_SOURCE_SELECT_ADDR) begin
            srcSel_q <= regWrData & MONO_OUTPUT_SOURCE_SELECT_MASK;
        end
    end

    // Mono level register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level_q <= MONO_OUTPUT_LEVEL_RST;
        end else if (regClear) begin
            level_q <= MONO_OUTPUT_LEVEL_RST;
        end else if (regWrStb && regAddr == MONO_OUTPUT_LEVEL_ADDR) begin
            level_q <= regWrData & MONO_OUTPUT_LEVEL_MASK;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdData_d = 8'h00;
        if (regRdStb) begin
            case (regAddr)
                MONO_MIX_SELECT_ADDR: rdData_d = mixSel_q;
                DIFFERENTIAL_INPUT_SELECT_ADDR: rdData_d = diffSel_q;
                MONO_OUTPUT_SOURCE_SELECT_ADDR: rdData_d = srcSel_q;
                MONO_OUTPUT_LEVEL_ADDR: rdData_d = level_q;
                default: rdData_d = 8'h00;
            endcase
        end
    end

    // Read data register, valid the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;

    // Pair average switches
    assign pairAvgToHeadphone = {mixSel_q[PAIR_THREE_HP_BIT],
                                 mixSel_q[PAIR_TWO_HP_BIT],
                                 mixSel_q[PAIR_ONE_HP_BIT]};
    assign pairAvgToLineout = {mixSel_q[PAIR_THREE_LO_BIT],
                               mixSel_q[PAIR_TWO_LO_BIT],
                               mixSel_q[PAIR_ONE_LO_BIT]};

    // Differential source switches, gated by the enable
    assign differentialMode = diffSel_q[DIFF_ENABLE_BIT];
    assign differentialToLineout = diffSel_q[DIFF_ENABLE_BIT];
    assign differentialToHeadphone = diffSel_q[DIFF_ENABLE_BIT] &
                                     diffSel_q[DIFF_TO_HP_BIT];
    assign differentialToMonoOutput = diffSel_q[DIFF_ENABLE_BIT] &
                                      diffSel_q[DIFF_TO_MONO_BIT];

    // Mono sum sources
    assign dacLeftToMono = srcSel_q[DAC_LEFT_MONO_BIT];
    assign dacRightToMono = srcSel_q[DAC_RIGHT_MONO_BIT];
    assign lineInToMono = srcSel_q[RIGHT_THREE_MONO_BIT:
                                   LEFT_ONE_MONO_BIT];

    // Mute forces the mute code; attenuation acts only when unmuted
    assign monoMuted = level_q[MUTE_BIT];
    assign monoAttenuation = level_q[MUTE_BIT] ? ATTEN_MUTED :
                             level_q[ATTEN_LSB+:ATTEN_W];

    // Gain and power of the mono stage
    assign monoDacGain = level_q[GAIN_BIT];
    assign monoPower = level_q[POWER_BIT];
    assign monoPinOe = level_q[POWER_BIT];
endmodule

// *** tb/mono_mix_asserts.sv ***
/*
 Checker of the mono mixing control outputs and register read port.
 Assumes it is bound to the top module and sees only its ports.
*/
module mono_mix_asserts
    import mono_mix_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset
    input wire logic powerDownPinN, // Power-down pin
    input wire logic [ADDR_W-1:0] regAddr, // Address
    input wire logic [DATA_W-1:0] regWrData, // Write data
    input wire logic regWrStb, // Write strobe
    input wire logic regRdStb, // Read strobe
    input wire logic [DATA_W-1:0] regRdData, // Read data
    input wire logic differentialMode, // Diff mode
    input wire logic differentialToLineout, // Diff to lineout
    input wire logic differentialToHeadphone, // Diff to HP
    input wire logic differentialToMonoOutput, // Diff to mono
    input wire logic [5:0] lineInToMono, // Inputs to mono
    input wire logic [3:0] monoAttenuation, // Attenuation
    input wire logic monoMuted, // Mute
    input wire logic monoDacGain, // Gain
    input wire logic monoPower, // Power
    input wire logic monoPinOe // Pin enable
);
    // One clock domain for every property
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_wr13;
        powerDownPinN [*3] ##0 (regWrStb && regAddr == 8'h13);
    endsequence
    sequence s_down;
        !powerDownPinN [*5];
    endsequence
    property p_lineDiff;
        differentialToLineout == differentialMode;
    endproperty
    a_lineDiff: assert property (p_lineDiff)
        else $error("lineout path");
    property p_hpDiff;
        differentialToHeadphone |-> differentialMode;
    endproperty
    a_hpDiff: assert property (p_hpDiff)
        else $error("hp path");
    property p_monoDiff;
        differentialToMonoOutput |-> differentialMode;
    endproperty
    a_monoDiff: assert property (p_monoDiff)
        else $error("mono path");
    property p_mute;
        monoMuted |-> monoAttenuation == 4'h0;
    endproperty
    a_mute: assert property (p_mute)
        else $error("mute gate");
    property p_oe;
        monoPinOe == monoPower;
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin enable");
    property p_wr13;
        s_wr13 |=> {1'b0, monoPower, monoDacGain, monoMuted, 4'h0} ==
            ($past(regWrData) & 8'h70);
    endproperty
    a_wr13: assert property (p_wr13)
        else $error("level write");
    property p_rd11;
        regRdStb && regAddr == 8'h11 && differentialMode |=>
            regRdData == {5'h00, differentialToMonoOutput,
                          differentialToHeadphone, 1'b1};
    endproperty
    a_rd11: assert property (p_rd11)
        else $error("diff readback");
    property p_down;
        s_down |-> monoMuted && !monoPower && lineInToMono == 6'h00;
    endproperty
    a_down: assert property (p_down)
        else $error("power-down");
endmodule
bind mono_mix_route_control mono_mix_asserts chk (.ref_clk, .rst,
    .powerDownPinN, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
    .differentialMode, .differentialToLineout, .differentialToHeadphone,
    .differentialToMonoOutput, .lineInToMono, .monoAttenuation, .monoMuted,
    .monoDacGain, .monoPower, .monoPinOe);

// *** tb/testbench.sv ***
/*
 Self-checking bench of the mono mixing control register slice.
 Assumes the package, design and checker are compiled before it.
*/
module testbench import mono_mix_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst = 1'b1, powerDownPinN = 1'b1;
    logic regWrStb = 1'b0, regRdStb = 1'b0, differentialMode;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [2:0] pairAvgToHeadphone, pairAvgToLineout;
    logic differentialToLineout, differentialToHeadphone, monoMuted;
    logic differentialToMonoOutput, dacLeftToMono, dacRightToMono;
    logic monoDacGain, monoPower, monoPinOe;
    logic [5:0] lineInToMono;
    logic [3:0] monoAttenuation;
    int nMismatch = 0, totalChecks = 0, cycles = 0;
    mono_mix_route_control DUT (.ref_clk, .rst, .powerDownPinN, .regAddr,
        .regWrData, .regWrStb, .regRdStb, .regRdData, .pairAvgToHeadphone,
        .pairAvgToLineout, .differentialMode, .differentialToLineout,
        .differentialToHeadphone, .differentialToMonoOutput, .dacLeftToMono,
        .dacRightToMono, .lineInToMono, .monoAttenuation, .monoMuted,
        .monoDacGain, .monoPower, .monoPinOe);
    // 200 MHz clock
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [7:0] exp, got);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrStb <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge ref_clk);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRdStb <= 1'b0;
        @(negedge ref_clk);
        chk($sformatf("reg %h", a), exp, regRdData);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_pairs();
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h3F);
        wr(8'h10, 8'h15);
        chk("avg hp", 8'h07, pairAvgToHeadphone);
        chk("avg lo", 8'h00, pairAvgToLineout);
        wr(8'h10, 8'h2A);
        chk("avg lo", 8'h07, pairAvgToLineout);
        $display("pairs done");
    endtask
    task automatic t_diff();
        wr(8'h11, 8'h06);
        chk("diff off", 8'h00, {differentialToMonoOutput,
            differentialToHeadphone});
        chk("diff mode off", 8'h00, differentialMode);
        wr(8'h11, 8'hFF);
        chk("diff on", 8'h07, {differentialToMonoOutput,
            differentialToHeadphone, differentialToLineout});
        chk("diff mode on", 8'h01, differentialMode);
        rd(8'h11, 8'h07);
        $display("diff done");
    endtask
    task automatic t_mono();
        wr(8'h12, 8'hA5);
        chk("mono src", 8'hA5, {lineInToMono, dacRightToMono,
            dacLeftToMono});
        wr(8'h13, 8'hFF);
        chk("muted lvl", 8'hF0, {monoPinOe, monoPower, monoDacGain,
            monoMuted, monoAttenuation});
        rd(8'h13, 8'h7F);
        wr(8'h13, 8'h6A);
        chk("open lvl", 8'hEA, {monoPinOe, monoPower, monoDacGain,
            monoMuted, monoAttenuation});
        $display("mono done");
    endtask
    task automatic t_pdn();
        @(posedge ref_clk);
        powerDownPinN <= 1'b0;
        repeat (4) @(posedge ref_clk);
        wr(8'h12, 8'hFF);
        @(posedge ref_clk);
        powerDownPinN <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(8'h12, 8'h00);
        rd(8'h13, 8'h10);
        chk("pin oe", 8'h00, monoPinOe);
        rd(8'h20, 8'h00);
        $display("power-down done");
    endtask
    // Cuts a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            nMismatch++;
            final_report();
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h13, 8'h10);
        rd(8'h12, 8'h00);
        t_pairs();
        t_diff();
        t_mono();
        t_pdn();
        final_report();
    end
endmodule
